// file: hw/piav_pkg.sv
// Purpose: Shared constants, types and helpers of the priority interrupt controller.
// Assumes: Eight request levels, level 0 has the highest priority.
// Notes:   Every figure used by the logic is named here except bit 7 and the zero fills of the low call byte.
package piav_pkg;

  localparam int NUM_LEVELS = 8;
  localparam int LVL_W      = 3;
  localparam int VBASE_W    = 5;

  typedef logic [NUM_LEVELS-1:0] piav_byte_t;
  typedef logic [LVL_W-1:0]      piav_lvl_t;

  localparam piav_byte_t CALL_OPCODE     = 8'hCD;
  localparam piav_byte_t MASK_RESET      = 8'h00;
  localparam piav_byte_t PEND_RESET      = 8'h00;
  localparam piav_byte_t ISR_RESET       = 8'h00;
  localparam piav_byte_t EDGE_PREV_RESET = 8'hFF;
  localparam piav_byte_t DATA_IDLE       = 8'h00;
  localparam piav_lvl_t  NO_GRANT_LEVEL  = 3'h7;
  localparam piav_lvl_t  CAS_IDLE        = 3'h0;

  // End of service command written with address line low.
  localparam int EOS_CMD_BIT      = 5;
  localparam int EOS_SPECIFIC_BIT = 6;

  // Programmed call address fields for the two address intervals.
  localparam int INT4_ADDR_LSB = 5;
  localparam int INT8_ADDR_LSB = 6;
  localparam int HI_ADDR_LSB   = 8;
  localparam int CALL_ADDR_MSB = 15;

  typedef enum logic [1:0] {
    ST_B1 = 2'h0,
    ST_B2 = 2'h1,
    ST_B3 = 2'h3
  } piav_strobe_e;

  // Index of the highest priority (lowest numbered) set bit; zero when none.
  function automatic piav_lvl_t first_set(input piav_byte_t v);
    piav_lvl_t r;
    r = '0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[LVL_W-1:0];
      end
    end
    return r;
  endfunction

  function automatic piav_byte_t one_hot(input piav_lvl_t l);
    return piav_byte_t'(1) << l;
  endfunction

endpackage

// file: hw/piav_core_if.sv
// Purpose: Carrier between the controller core, request capture and priority logic.
// Assumes: One clock domain.
// Notes:   No clocking block; all signals are plain levels.
`timescale 1ns/100ps
`default_nettype none
interface piav_core_if;
  piav_pkg::piav_byte_t pending;
  piav_pkg::piav_byte_t mask;
  piav_pkg::piav_byte_t in_service;
  piav_pkg::piav_byte_t grant_clr;
  logic                 level_trig;
  logic                 req_valid;
  piav_pkg::piav_lvl_t  req_level;

  modport req  (output pending, input grant_clr, input level_trig);
  modport prio (input pending, input mask, input in_service,
                output req_valid, output req_level);
  modport core (input pending, input req_valid, input req_level,
                output mask, output in_service, output grant_clr, output level_trig);
endinterface
`default_nettype wire

// file: hw/piav_req.sv
// Purpose: Request capture into the pending request bits.
// Assumes: Request inputs are synchronous to clock.
// Notes:   Edge sense starts high so a request held over reset must fall first.
`timescale 1ns/100ps
`default_nettype none
module piav_req (
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire piav_pkg::piav_byte_t request_inputs,
  piav_core_if.req                 cif
);
  piav_pkg::piav_byte_t prev_q;
  piav_pkg::piav_byte_t pend_q;

  for (genvar i = 0; i < piav_pkg::NUM_LEVELS; i++) begin : g_lvl
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        prev_q[i] <= piav_pkg::EDGE_PREV_RESET[i];
        pend_q[i] <= piav_pkg::PEND_RESET[i];
      end else begin
        prev_q[i] <= request_inputs[i];
        if (cif.level_trig) begin
          pend_q[i] <= request_inputs[i]; // R1 R21
        end else if (request_inputs[i] && !prev_q[i]) begin
          pend_q[i] <= 1'b1; // R1 R21
        end else if (cif.grant_clr[i] || !request_inputs[i]) begin
          pend_q[i] <= 1'b0; // R4 R21
        end
      end
    end
  end

  assign cif.pending = pend_q;
endmodule // piav_req
`default_nettype wire

// file: hw/piav_prio.sv
// Purpose: Priority decision between pending, mask and in-service bits.
// Assumes: Fixed priority, level 0 highest.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module piav_prio (
  piav_core_if.prio cif
);
  piav_pkg::piav_byte_t eligible;
  piav_pkg::piav_lvl_t  top_req;
  piav_pkg::piav_lvl_t  top_isr;

  assign eligible = cif.pending & ~cif.mask; // R20
  assign top_req  = piav_pkg::first_set(eligible);
  assign top_isr  = piav_pkg::first_set(cif.in_service);

  // A request wins only over strictly lower priority levels in service.
  assign cif.req_valid = (|eligible) &&
                         (!(|cif.in_service) || (top_req < top_isr)); // R2 R20
  assign cif.req_level = top_req;
endmodule // piav_prio
`default_nettype wire

// file: hw/piav_top.sv
// Purpose: Eight level priority interrupt controller with call and vector replies.
// Assumes: All pins are synchronous to clock; configuration ports are static.
// Notes:   Output enables are active low; data and cascade outputs come from flops.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (R1) A request input going high sets its pending request bit.
// (R2) Interrupt output rises for an unmasked request above every level in service.
// (R3) Call mode is used unless vector mode is configured; it takes three strobes.
// (R4) First strobe sets the winner's in-service bit and, in edge mode, clears its pending bit.
// (R5) Call mode drives the CALL opcode CD hex during the first strobe.
// (R6) The host follows the opcode with two more acknowledge strobes.
// (R7) Call mode returns the low address byte then the high address byte.
// (R8) Interval four: address bits 7..5, level in 4..2, zeros below.
// (R9) Interval eight: address bits 7..6, level in 5..3, zeros below.
// (R10) Third call byte carries the programmed address bits 15..8.
// (R11) Call mode with auto end of service clears in-service when strobe three ends.
// (R12) Without auto end of service the bit waits for an end of service command.
// (R13) Vector mode leaves the data bus undriven during the first strobe.
// (R14) First strobe freezes the grant; a cascade master drives the code out.
// (R15) Vector mode drives one vector byte during the second strobe.
// (R16) Vector byte holds the five base bits over the three level bits.
// (R17) Vector mode with auto end of service clears in-service after strobe two.
// (R18) A three line cascade bus links one master with up to eight slaves.
// (R19) Host reads give pending, in-service or mask bits, never stored settings.
// (R20) The winner depends on priority order, mode, mask and in-service bits.
// (R21) Edge mode needs a rising edge held high; level mode needs a high level.
// (R22) Acknowledge ignores chip select; host reads and writes need it low.
// (R23) The data bus is released outside answered strobes and selected reads.
// (R24) With no valid request the strobe sequence completes without in-service.
module piav_top (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire piav_pkg::piav_byte_t    request_inputs,
  input  wire piav_pkg::piav_byte_t    d_in,
  output logic [7:0]                   d_out,
  output logic                         d_oe_b,
  input  wire logic                    cs_b,
  input  wire logic                    rd_b,
  input  wire logic                    wr_b,
  input  wire logic                    a0,
  input  wire logic                    cpu_acknowledge_strobe_b,
  output logic                         int_out,
  input  wire piav_pkg::piav_lvl_t     cas_in,
  output logic [2:0]                   cas_out,
  output logic                         cas_oe_b,
  input  wire logic                    cfg_vector_mode,
  input  wire logic                    cfg_auto_end_of_service,
  input  wire logic                    cfg_interval_four,
  input  wire logic                    cfg_level_trig,
  input  wire logic                    cfg_cascaded,
  input  wire logic                    cfg_master,
  input  wire piav_pkg::piav_lvl_t     cfg_slave_id,
  input  wire piav_pkg::piav_byte_t    cfg_slave_map,
  input  wire logic [15:5]             cfg_call_addr,
  input  wire logic [4:0]              cfg_vector_base,
  input  wire logic                    cfg_read_in_service
);

  piav_core_if cif ();

  piav_req u_req (
    .clock          (clock),
    .rst_b          (rst_b),
    .request_inputs (request_inputs),
    .cif            (cif.req)
  );

  piav_prio u_prio (
    .cif (cif.prio)
  );

  piav_pkg::piav_strobe_e strobe_q;
  piav_pkg::piav_strobe_e strobe_d;
  piav_pkg::piav_strobe_e last_strobe;

  logic                 ack_prev_q;
  logic                 wr_prev_q;
  logic                 ack_fall;
  logic                 ack_rise;
  logic                 first_fall;
  logic                 seq_end;
  logic                 seq_busy_q;
  logic                 gnt_valid_q;
  piav_pkg::piav_lvl_t  gnt_level_q;
  piav_pkg::piav_byte_t mask_q;
  piav_pkg::piav_byte_t isr_q;
  piav_pkg::piav_byte_t isr_set;
  piav_pkg::piav_byte_t isr_clr;
  piav_pkg::piav_byte_t eos_clr;
  piav_pkg::piav_byte_t auto_end_of_service_clr;
  logic                 wr_take;
  logic                 rd_take;
  logic                 is_slave;
  logic                 slave_below;
  logic                 cas_match;
  logic                 byte_enable;
  logic                 drive_ack;
  piav_pkg::piav_byte_t ack_byte;
  piav_pkg::piav_byte_t rd_byte;
  logic [7:0]           d_out_q;
  logic                 d_oe_b_q;
  piav_pkg::piav_lvl_t  cas_out_q;
  logic                 cas_oe_b_q;
  logic                 int_q;

  // Strobe edges; the strobe works with or without chip select.
  assign ack_fall   = !cpu_acknowledge_strobe_b && ack_prev_q; // R22
  assign ack_rise   = cpu_acknowledge_strobe_b && !ack_prev_q;
  assign first_fall = ack_fall && (strobe_q == piav_pkg::ST_B1);

  // Vector mode ends after the second strobe, call mode after the third.
  assign last_strobe = cfg_vector_mode ? piav_pkg::ST_B2 : piav_pkg::ST_B3; // R3
  assign seq_end     = ack_rise && (strobe_q == last_strobe);

  // Host writes are taken once per write strobe, reads for the whole read strobe; chip select low.
  assign wr_take = !cs_b && !wr_b && wr_prev_q && rd_b; // R22
  assign rd_take = !cs_b && !rd_b && wr_b;              // R22

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_prev_q <= 1'b1;
      wr_prev_q  <= 1'b1;
    end else begin
      ack_prev_q <= cpu_acknowledge_strobe_b;
      wr_prev_q  <= wr_b;
    end
  end

  // Strobe sequencer: the state names the strobe being served or awaited.
  always_comb begin
    strobe_d = strobe_q;
    if (ack_rise) begin
      unique case (strobe_q)
        piav_pkg::ST_B1: strobe_d = piav_pkg::ST_B2; // R6
        piav_pkg::ST_B2: strobe_d = cfg_vector_mode ? piav_pkg::ST_B1 : piav_pkg::ST_B3;
        piav_pkg::ST_B3: strobe_d = piav_pkg::ST_B1;
        default:         strobe_d = piav_pkg::ST_B1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= piav_pkg::ST_B1;
    end else begin
      strobe_q <= strobe_d; // R3
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seq_busy_q <= 1'b0;
    end else if (first_fall) begin
      seq_busy_q <= 1'b1;
    end else if (seq_end) begin
      seq_busy_q <= 1'b0;
    end
  end

  // The grant is frozen at the first strobe and used by every later byte.
  // With nothing to grant the sequence still runs, carrying NO_GRANT_LEVEL (7).
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gnt_valid_q <= 1'b0;
      gnt_level_q <= piav_pkg::NO_GRANT_LEVEL;
    end else if (first_fall) begin
      gnt_valid_q <= cif.req_valid; // R14 R24
      gnt_level_q <= cif.req_valid ? cif.req_level : piav_pkg::NO_GRANT_LEVEL; // R14 R24
    end
  end

  // In edge mode the winner's pending bit is dropped in the same cycle its in-service bit rises.
  assign isr_set = (first_fall && cif.req_valid) ?
                   piav_pkg::one_hot(cif.req_level) : '0; // R4 R24
  assign cif.grant_clr = isr_set; // R4

  // Auto end of service fires as the last strobe of the sequence ends.
  assign auto_end_of_service_clr = (seq_end && cfg_auto_end_of_service && gnt_valid_q) ?
                    piav_pkg::one_hot(gnt_level_q) : '0; // R11 R17

  // End of service command: specific level, or the highest level in service.
  always_comb begin
    eos_clr = '0;
    if (wr_take && !a0 && d_in[piav_pkg::EOS_CMD_BIT]) begin
      if (d_in[piav_pkg::EOS_SPECIFIC_BIT]) begin
        eos_clr = piav_pkg::one_hot(d_in[piav_pkg::LVL_W-1:0]); // R12
      end else if (|isr_q) begin
        eos_clr = piav_pkg::one_hot(piav_pkg::first_set(isr_q)); // R12
      end
    end
  end

  assign isr_clr = eos_clr | auto_end_of_service_clr;

  // A grant in the same cycle as a clear of that level keeps the bit set.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      isr_q <= piav_pkg::ISR_RESET;
    end else begin
      isr_q <= (isr_q & ~isr_clr) | isr_set; // R4 R11 R12 R17
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= piav_pkg::MASK_RESET;
    end else if (wr_take && a0) begin
      mask_q <= d_in; // R20
    end
  end

  assign cif.mask       = mask_q;
  assign cif.in_service = isr_q;
  assign cif.level_trig = cfg_level_trig; // R21

  // Cascade roles: a slave answers only when the master calls its code;
  // a master stays quiet on later bytes when a slave hangs off the level.
  assign is_slave    = cfg_cascaded && !cfg_master; // R18
  assign slave_below = cfg_cascaded && cfg_master && cfg_slave_map[gnt_level_q]; // R18
  assign cas_match   = (cas_in == cfg_slave_id); // R18

  always_comb begin
    byte_enable = 1'b0;
    unique case (strobe_q)
      piav_pkg::ST_B1: byte_enable = !cfg_vector_mode && !is_slave; // R5 R13
      piav_pkg::ST_B2: byte_enable = is_slave ? cas_match : !slave_below; // R7 R15
      piav_pkg::ST_B3: byte_enable = !cfg_vector_mode &&
                                     (is_slave ? cas_match : !slave_below); // R7
      default:         byte_enable = 1'b0;
    endcase
  end

  // Byte returned for the current strobe.
  always_comb begin
    ack_byte = piav_pkg::DATA_IDLE;
    unique case (strobe_q)
      piav_pkg::ST_B1: ack_byte = piav_pkg::CALL_OPCODE; // R5
      piav_pkg::ST_B2: begin
        if (cfg_vector_mode) begin
          ack_byte = {cfg_vector_base, gnt_level_q}; // R15 R16
        end else if (cfg_interval_four) begin
          ack_byte = {cfg_call_addr[7:piav_pkg::INT4_ADDR_LSB], gnt_level_q, 2'h0}; // R8
        end else begin
          ack_byte = {cfg_call_addr[7:piav_pkg::INT8_ADDR_LSB], gnt_level_q, 3'h0}; // R9
        end
      end
      piav_pkg::ST_B3: begin
        ack_byte = cfg_call_addr[piav_pkg::CALL_ADDR_MSB:piav_pkg::HI_ADDR_LSB]; // R10
      end
      default:         ack_byte = piav_pkg::DATA_IDLE;
    endcase
  end

  // Status read; stored settings have no read path at all.
  assign rd_byte = a0 ? mask_q : (cfg_read_in_service ? isr_q : cif.pending); // R19

  assign drive_ack = !cpu_acknowledge_strobe_b && byte_enable; // R13 R23

  // The bus follows the strobe one cycle late and is released one cycle after it.
  // An acknowledge byte wins over a read that overlaps it.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      d_out_q  <= piav_pkg::DATA_IDLE;
      d_oe_b_q <= 1'b1;
    end else begin
      d_oe_b_q <= !(drive_ack || rd_take); // R13 R23
      if (drive_ack) begin
        d_out_q <= ack_byte; // R5 R7 R15
      end else if (rd_take) begin
        d_out_q <= rd_byte; // R19
      end else begin
        d_out_q <= piav_pkg::DATA_IDLE;
      end
    end
  end

  // A cascade master puts the granted code out from the first strobe
  // and keeps it until the sequence ends so slaves can match on later bytes.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cas_out_q  <= piav_pkg::CAS_IDLE;
      cas_oe_b_q <= 1'b1;
    end else if (cfg_cascaded && cfg_master && first_fall) begin
      cas_out_q  <= cif.req_valid ? cif.req_level : piav_pkg::NO_GRANT_LEVEL; // R14 R18
      cas_oe_b_q <= 1'b0; // R14
    end else if (!seq_busy_q || !cfg_cascaded || !cfg_master) begin
      cas_out_q  <= piav_pkg::CAS_IDLE;
      cas_oe_b_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_q <= 1'b0;
    end else begin
      int_q <= cif.req_valid; // R2
    end
  end

  assign d_out    = d_out_q;
  assign d_oe_b   = d_oe_b_q;
  assign cas_out  = cas_out_q;
  assign cas_oe_b = cas_oe_b_q;
  assign int_out  = int_q;

endmodule // piav_top
`default_nettype wire

// file: dv/piav_asserts.sv
// Purpose: Port level assertions for the interrupt controller top.
// Assumes: Configuration ports stay still while a strobe sequence runs.
// Notes:   The strobe count is rebuilt here from strobe falls.
`timescale 1ns/100ps
`default_nettype none
module piav_asserts (
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire piav_pkg::piav_byte_t request_inputs,
  input wire logic [7:0]           d_out,
  input wire logic                 d_oe_b,
  input wire logic                 cs_b,
  input wire logic                 rd_b,
  input wire logic                 wr_b,
  input wire logic                 cpu_acknowledge_strobe_b,
  input wire logic                 int_out,
  input wire logic                 cas_oe_b,
  input wire logic                 cfg_vector_mode,
  input wire logic                 cfg_interval_four,
  input wire logic                 cfg_cascaded,
  input wire logic                 cfg_master,
  input wire logic [15:5]          cfg_call_addr,
  input wire logic [4:0]           cfg_vector_base
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [1:0] stb_q;
  wire logic  slave = cfg_cascaded && !cfg_master;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stb_q <= 2'h0;
    end else if ($fell(cpu_acknowledge_strobe_b)) begin
      stb_q <= (stb_q == (cfg_vector_mode ? 2'h1 : 2'h2)) ? 2'h0 : stb_q + 2'h1;
    end
  end
  bus_release_a: assert property (
    !d_oe_b |-> !$past(cpu_acknowledge_strobe_b) || (!$past(cs_b) && !$past(rd_b) && $past(wr_b)))
    else $error("data bus driven without cause");
  int_cause_a: assert property (
    $rose(int_out) |-> $past(request_inputs, 2) != 8'h00)
    else $error("interrupt without request");
  call_open_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h0 && !cfg_vector_mode && !slave
    |=> !d_oe_b && d_out == piav_pkg::CALL_OPCODE) else $error("opcode byte wrong");
  vec_quiet_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h0 && cfg_vector_mode |=> d_oe_b [*2])
    else $error("first vector strobe drove the bus");
  vec_base_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h1 && cfg_vector_mode && !cfg_cascaded
    |=> !d_oe_b && d_out[7:3] == cfg_vector_base) else $error("vector base wrong");
  low_four_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h1 && !cfg_vector_mode && cfg_interval_four
    && !cfg_cascaded |=> d_out[7:5] == cfg_call_addr[7:5] && d_out[1:0] == 2'h0)
    else $error("interval four low byte wrong");
  low_eight_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h1 && !cfg_vector_mode && !cfg_interval_four
    && !cfg_cascaded |=> d_out[7:6] == cfg_call_addr[7:6] && d_out[2:0] == 3'h0)
    else $error("interval eight low byte wrong");
  high_byte_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h2 && !cfg_vector_mode && !cfg_cascaded
    |=> !d_oe_b && d_out == cfg_call_addr[15:8]) else $error("high address byte wrong");
  cas_grant_a: assert property (
    $fell(cpu_acknowledge_strobe_b) && stb_q == 2'h0 && cfg_cascaded && cfg_master
    |=> !cas_oe_b) else $error("master did not drive cascade code");
  cas_quiet_a: assert property (
    !cfg_cascaded && !$past(cfg_cascaded) |-> cas_oe_b) else $error("cascade driven alone");
endmodule // piav_asserts
bind piav_top piav_asserts u_asserts (
  .clock(clock), .rst_b(rst_b), .request_inputs(request_inputs), .d_out(d_out),
  .d_oe_b(d_oe_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .int_out(int_out),
  .cpu_acknowledge_strobe_b(cpu_acknowledge_strobe_b), .cas_oe_b(cas_oe_b),
  .cfg_vector_mode(cfg_vector_mode), .cfg_interval_four(cfg_interval_four),
  .cfg_cascaded(cfg_cascaded), .cfg_master(cfg_master), .cfg_call_addr(cfg_call_addr),
  .cfg_vector_base(cfg_vector_base));
`default_nettype wire

// file: dv/piav_host_model.sv
// Purpose: Host processor side that issues acknowledge strobe sequences.
// Assumes: Strobes are held for at least two edges and spaced by three.
// Notes:   The byte is taken at the edge before the strobe is raised.
`timescale 1ns/100ps
`default_nettype none
module piav_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] d_out,
  input  wire logic       d_oe_b,
  output logic            ack_b
);
  logic [7:0] got [0:2];
  logic       oe_seen [0:2];
  logic       freed;
  initial ack_b = 1'b1;
  // Strobes never look at chip select, so the bench leaves it high meanwhile.
  task automatic run(input int n, input int hold);
    freed = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1 ack_b = 1'b0;
      repeat (hold) @(posedge clock);
      got[i] = d_out;
      oe_seen[i] = d_oe_b;
      #1 ack_b = 1'b1;
      repeat (2) @(posedge clock);
      freed = freed & d_oe_b;
    end
  endtask
endmodule // piav_host_model
`default_nettype wire

// file: dv/priority_interrupt_ack_vectoring_tb.sv
// Purpose: Self-checking bench for the interrupt controller top.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Cascade slave inputs are tied; only the master side is exercised.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_ack_vectoring_tb;
  logic                 clock = 1'b0;
  logic                 rst_b;
  piav_pkg::piav_byte_t req;
  piav_pkg::piav_byte_t d_in;
  logic [7:0]           d_out;
  logic [2:0]           cas_out;
  logic                 d_oe_b, cs_b, rd_b, wr_b, a0, ack_b, int_out, cas_oe_b;
  logic                 vec, aeos, i4, lvl, casc, mst, rd_isr;
  logic [15:5]          caddr;
  logic [4:0]           vbase;
  int                   fails = 0;
  int                   total_checks = 0;
  int                   cycles = 0;
  always #12.5 clock = ~clock;
  piav_top u_dut (.clock(clock), .rst_b(rst_b), .request_inputs(req), .d_in(d_in),
    .d_out(d_out), .d_oe_b(d_oe_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .a0(a0),
    .cpu_acknowledge_strobe_b(ack_b), .int_out(int_out), .cas_in(3'h0), .cas_out(cas_out),
    .cas_oe_b(cas_oe_b), .cfg_vector_mode(vec), .cfg_auto_end_of_service(aeos),
    .cfg_interval_four(i4), .cfg_level_trig(lvl), .cfg_cascaded(casc), .cfg_master(mst),
    .cfg_slave_id(3'h0), .cfg_slave_map(8'h00), .cfg_call_addr(caddr),
    .cfg_vector_base(vbase), .cfg_read_in_service(rd_isr));
  piav_host_model u_host (.clock(clock), .d_out(d_out), .d_oe_b(d_oe_b), .ack_b(ack_b));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic adr, input logic [7:0] val);
    @(posedge clock);
    #1 {cs_b, wr_b, a0, d_in} = {2'b00, adr, val};
    @(posedge clock);
    #1 {cs_b, wr_b} = 2'b11;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic adr, input logic [7:0] exp);
    @(posedge clock);
    #1 {cs_b, rd_b, a0} = {2'b00, adr};
    repeat (2) @(posedge clock);
    chk({7'h00, d_oe_b}, 8'h00);
    chk(d_out, exp);
    #1 {cs_b, rd_b} = 2'b11;
    repeat (2) @(posedge clock);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    {d_in, cs_b, rd_b, wr_b, a0} = {8'h00, 4'hE};
    {vec, aeos, i4, lvl, casc, mst, rd_isr} = 7'h00;
    caddr = 11'h5A6;
    vbase = 5'h15;
    rst_b = 1'b0;
    // A request held through reset must not count in edge mode.
    req = 8'h01;
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    chk({7'h00, d_oe_b}, 8'h01);
    rd_reg(1'b1, 8'h00);
    rd_reg(1'b0, 8'h00);
    chk({7'h00, int_out}, 8'h00);
    #1 rd_b = 1'b0;
    repeat (2) @(posedge clock);
    chk({7'h00, d_oe_b}, 8'h01);
    #1 {rd_b, lvl} = 2'b11;
    repeat (3) @(posedge clock);
    chk({7'h00, int_out}, 8'h01);
    #1 {req, lvl, i4} = {8'h00, 2'b01};
    repeat (3) @(posedge clock);
    #1 req = 8'h20;
    repeat (3) @(posedge clock);
    chk({7'h00, int_out}, 8'h01);
    rd_reg(1'b0, 8'h20);
    u_host.run(3, 2);
    chk(u_host.got[0], piav_pkg::CALL_OPCODE);
    chk(u_host.got[1], {caddr[7:5], 3'h5, 2'h0});
    chk(u_host.got[2], caddr[15:8]);
    chk({5'h00, u_host.oe_seen[0], u_host.oe_seen[1], u_host.oe_seen[2]}, 8'h00);
    chk({7'h00, u_host.freed}, 8'h01);
    chk({7'h00, int_out}, 8'h00);
    rd_reg(1'b0, 8'h00);
    #1 rd_isr = 1'b1;
    rd_reg(1'b0, 8'h20);
    wr_reg(1'b0, 8'h20);
    rd_reg(1'b0, 8'h00);
    #1 {req, i4, aeos} = {8'h00, 2'b01};
    wr_reg(1'b1, 8'h04);
    rd_reg(1'b1, 8'h04);
    #1 req = 8'h44;
    repeat (3) @(posedge clock);
    u_host.run(3, 2);
    chk(u_host.got[1], {caddr[7:6], 3'h6, 3'h0});
    chk(u_host.got[2], caddr[15:8]);
    rd_reg(1'b0, 8'h00);
    chk({7'h00, int_out}, 8'h00);
    wr_reg(1'b1, 8'h00);
    repeat (2) @(posedge clock);
    chk({7'h00, int_out}, 8'h01);
    u_host.run(3, 2);
    chk(u_host.got[1], {caddr[7:6], 3'h2, 3'h0});
    #1 {req, vec, lvl} = {8'h08, 2'b11};
    repeat (3) @(posedge clock);
    u_host.run(2, 5);
    chk({7'h00, u_host.oe_seen[0]}, 8'h01);
    chk({7'h00, u_host.oe_seen[1]}, 8'h00);
    chk(u_host.got[1], {vbase, 3'h3});
    #1 req = 8'h00;
    rd_reg(1'b0, 8'h00);
    #1 {vec, lvl, aeos, casc, mst, i4} = 6'h0F;
    repeat (3) @(posedge clock);
    // The cascade code is only out while the sequence runs, so it is sampled mid-sequence.
    fork
      u_host.run(3, 2);
      begin
        repeat (3) @(posedge clock);
        #1 chk({5'h00, cas_out}, {5'h00, piav_pkg::NO_GRANT_LEVEL});
        chk({7'h00, cas_oe_b}, 8'h00);
      end
    join
    chk(u_host.got[0], piav_pkg::CALL_OPCODE);
    chk(u_host.got[1], {caddr[7:5], 3'h7, 2'h0});
    #1 chk({7'h00, cas_oe_b}, 8'h01);
    rd_reg(1'b0, 8'h00);
    #1 casc = 1'b0;
    repeat (2) @(posedge clock);
    give_verdict();
  end
endmodule // priority_interrupt_ack_vectoring_tb
`default_nettype wire
